/* lcd_port_pkg.sv */
// constants, types and command codes of the serial command port
// assumes one 10 MHz clock and a synchronous active-low reset
`default_nettype none
package lcd_port_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int FRAME_HZ = 80;
   localparam int FRAME_DIV_CYC = CLK_HZ / FRAME_HZ;
   localparam int KEY_STEP_US = 100;
   localparam int KEY_STEP_CYC = (CLK_HZ / 1_000_000) * KEY_STEP_US;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [3:0] BIT_CNT_ONE = 4'h1;
   localparam logic [7:0] CMD_DISPLAY_WRITE = 8'hA0;
   localparam logic [7:0] CMD_KEY_READ = 8'hB0;
   localparam logic [1:0] ADDR_SET_TAG = 2'h0;
   localparam logic [3:0] CMD_DRIVE_CTRL = 4'h8;
   localparam logic [3:0] CMD_PORT_CTRL = 4'h9;
   localparam logic [3:0] CMD_GPO_DATA = 4'hC;
   localparam logic [3:0] CMD_DIV_RATIO = 4'hD;
   localparam logic [3:0] CMD_PIN_CTRL = 4'hE;
   localparam logic [1:0] CLKSEL_EXT = 2'h3;
   localparam int RAM_DEPTH = 51;
   localparam int RAM_WIDTH = 4;
   localparam int ADDR_W = 6;
   localparam logic [5:0] ADDR_LAST = 6'h32;
   localparam logic [5:0] ADDR_ONE = 6'h01;
   localparam logic [2:0] GROUP_QUARTER = 3'h4;
   localparam logic [2:0] GROUP_THIRD = 3'h3;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   localparam int KEY_SCAN_N = 6;
   localparam int KEY_SENSE_N = 5;
   localparam int KEY_BITS = 30;
   localparam int KEY_SHIFT_W = 32;
   localparam logic [1:0] KEY_PAD = 2'h3;
   localparam logic [2:0] SCAN_LAST = 3'h5;
   localparam logic [5:0] SCAN_ONE = 6'h01;
   localparam logic [7:0] EXT_DIV_LOW = 8'hFF;
   localparam logic [3:0] DRIVE_CTRL_RST = 4'h2;
   localparam logic [3:0] DIV_RATIO_RST = 4'h0;
   localparam logic [3:0] GPO_RST = 4'h0;
   localparam logic [2:0] PIN_CTRL_RST = 3'h0;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      MODE_CMD = 2'b00,
      MODE_DATA = 2'b01,
      MODE_READ = 2'b10
   } port_mode_t;

   typedef enum logic [1:0] {
      ENT_DATA = 2'b00,
      ENT_ADDR = 2'b01,
      ENT_FLUSH = 2'b10
   } entry_kind_t;

   typedef struct packed {
      entry_kind_t kind;
      logic [7:0] payload;
   } fifo_entry_t;

   typedef struct packed {
      logic [1:0] clock_select_field;
      logic quarter_duty;
      logic bias_third;
   } drive_ctrl_t;

   typedef struct packed {
      logic display_on;
      logic key_scan_seg;
      logic key_sense_seg;
   } pin_ctrl_t;
endpackage
`default_nettype wire

/* entry_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module entry_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != CNT_FULL);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];

   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data_i;
         wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      mem_q <= mem_d;
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   property p_fifo_bound;
      @(posedge mclk_i) disable iff (!rst_n_i)
      cnt_q == CNT_FULL && !pop |=> cnt_q == CNT_FULL;
   endproperty
   a_fifo_bound: assert property (p_fifo_bound)
      else $error("fifo lost an entry while full");
endmodule
`default_nettype wire

/* lcd_serial_command_port.sv */
// three-wire serial command port with display ram, key scan and divider
// assumes pins synchronous to mclk_i and the serial clock well below it
// Notes on behaviour
// R1 - chip select high clears bit counter
// R2 - serial inputs honoured only with select low
// R3 - host sends bytes msb first
// R4 - sample on rise, byte on eighth fall
// R5 - short byte at select rise is dropped
// R6 - key read enters read mode, shifts out
// R7 - select high leaves read mode at once
// R8 - first byte after select fall is command
// R9 - other commands keep command mode
// R10 - display write makes later bytes data
// R11 - data mode decodes no commands
// R12 - display ram of 51 four-bit words
// R13 - address set, step per group by duty
// R14 - reset pin low blocks transfers, display
// R15 - fourth common becomes segment in third duty
// R16 - first four segments switch to gpo
// R17 - scan and sense lines become segments
// R18 - thirty keys, scan only on press
// R19 - duty and bias selectable
// R20 - clock select 11 divides external clock
// R21 - host holds external clock low otherwise
// R22 - host pulls up open-drain key output
// R23 - commit by group, drop short group
// R24 - key output released outside read mode
// R25 - each select fall restarts command decode
`timescale 1ns/1ns
`default_nettype none
module lcd_serial_command_port
   import lcd_port_pkg::*;
#(
   parameter int INT_FRAME_DIV = FRAME_DIV_CYC
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic chip_select_low_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_in_i,
   input wire logic reset_in_low_i,
   input wire logic ext_clock_in_i,
   input wire logic [KEY_SENSE_N-1:0] key_sense_in_i,
   output logic key_data_out_o,
   output logic key_data_oe_n_o,
   output logic [KEY_SCAN_N-1:0] key_scan_out_o,
   output logic [RAM_DEPTH*RAM_WIDTH-1:0] display_ram_o,
   output logic display_enable_o,
   output logic quarter_duty_o,
   output logic bias_third_o,
   output logic common4_is_seg41_o,
   output logic [3:0] gpo_enable_o,
   output logic [3:0] gpo_level_o,
   output logic key_scan_is_seg_o,
   output logic key_sense_is_seg_o,
   output logic frame_tick_o,
   output logic fifo_overrun_o
);
   localparam int FRAME_CNT_W = ($clog2(INT_FRAME_DIV) > 12) ?
      $clog2(INT_FRAME_DIV) : 12;
   localparam int STEP_W = $clog2(KEY_STEP_CYC);

   // serial front end and command decode
   logic sclk_q, sclk_d, active_q, active_d, read_pend_q, read_pend_d;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   port_mode_t mode_q, mode_d;
   logic [KEY_SHIFT_W-1:0] key_sh_q, key_sh_d;
   logic key_oe_n_q, key_oe_n_d, flush_pend_q, flush_pend_d;
   logic overrun_q, overrun_d;
   drive_ctrl_t drive_q, drive_d;
   pin_ctrl_t pin_q, pin_d;
   logic [3:0] gpo_en_q, gpo_en_d, gpo_lvl_q, gpo_lvl_d, ratio_q, ratio_d;
   logic active, rise, fall, frame_end, push_valid, push_ready;
   fifo_entry_t push_entry;
   logic [KEY_BITS-1:0] key_q, key_d;

   // R2 R14
   assign active = !chip_select_low_i && reset_in_low_i;
   assign rise = active && serial_clock_i && !sclk_q;
   assign fall = active && !serial_clock_i && sclk_q;
   assign frame_end = active_q && !active;

   always_comb begin
      logic data_req;
      data_req = 1'b0;
      sclk_d = serial_clock_i;
      active_d = active;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      mode_d = mode_q;
      read_pend_d = read_pend_q;
      key_sh_d = key_sh_q;
      drive_d = drive_q;
      pin_d = pin_q;
      gpo_en_d = gpo_en_q;
      gpo_lvl_d = gpo_lvl_q;
      ratio_d = ratio_q;
      flush_pend_d = flush_pend_q;
      overrun_d = overrun_q;
      push_valid = 1'b0;
      push_entry = '{kind: ENT_DATA, payload: shift_q};
      if (!active) begin
         bit_cnt_d = '0; // R1 R5
         mode_d = MODE_CMD; // R7 R25
         read_pend_d = 1'b0;
      end else begin
         if (rise) begin
            shift_d = {shift_q[6:0], serial_data_in_i}; // R3 R4
            bit_cnt_d = bit_cnt_q + BIT_CNT_ONE;
            if (bit_cnt_q == BIT_CNT_FULL - BIT_CNT_ONE &&
                mode_q == MODE_CMD) begin
               read_pend_d = (shift_d == CMD_KEY_READ); // R6
            end
         end
         if (fall && mode_q == MODE_READ) begin
            key_sh_d = {key_sh_q[KEY_SHIFT_W-2:0], 1'b1}; // R6
         end
         if (fall && bit_cnt_q == BIT_CNT_FULL) begin
            bit_cnt_d = '0; // R4
            read_pend_d = 1'b0;
            case (mode_q)
               MODE_CMD: begin // R8 R9
                  if (read_pend_q) begin
                     mode_d = MODE_READ; // R6
                     key_sh_d = {key_q, KEY_PAD};
                  end else if (shift_q == CMD_DISPLAY_WRITE) begin
                     mode_d = MODE_DATA; // R10
                  end else if (shift_q[7:6] == ADDR_SET_TAG) begin
                     data_req = 1'b1; // R13
                     push_entry.kind = ENT_ADDR;
                  end else if (shift_q[7:4] == CMD_DRIVE_CTRL) begin
                     drive_d = drive_ctrl_t'(shift_q[3:0]); // R19
                  end else if (shift_q[7:4] == CMD_PORT_CTRL) begin
                     gpo_en_d = shift_q[3:0]; // R16
                  end else if (shift_q[7:4] == CMD_GPO_DATA) begin
                     gpo_lvl_d = shift_q[3:0]; // R16
                  end else if (shift_q[7:4] == CMD_DIV_RATIO) begin
                     ratio_d = shift_q[3:0]; // R20
                  end else if (shift_q[7:4] == CMD_PIN_CTRL) begin
                     pin_d = pin_ctrl_t'(shift_q[2:0]); // R17
                  end
               end
               MODE_DATA: begin
                  data_req = 1'b1; // R10 R11
               end
               default: begin
               end
            endcase
         end
      end
      if (frame_end || flush_pend_q) begin
         push_valid = 1'b1; // R23
         push_entry = '{kind: ENT_FLUSH, payload: 8'h00};
         flush_pend_d = !push_ready;
      end else begin
         push_valid = data_req;
      end
      if ((push_valid && !push_ready) || (data_req && flush_pend_q)) begin
         overrun_d = 1'b1;
      end
      // R22 R24
      key_oe_n_d = !(mode_d == MODE_READ && !key_sh_d[KEY_SHIFT_W-1]);
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
         active_q <= 1'b0;
         bit_cnt_q <= '0;
         shift_q <= '0;
         mode_q <= MODE_CMD;
         read_pend_q <= 1'b0;
         key_sh_q <= '1;
         key_oe_n_q <= 1'b1;
         drive_q <= drive_ctrl_t'(DRIVE_CTRL_RST);
         pin_q <= pin_ctrl_t'(PIN_CTRL_RST);
         gpo_en_q <= GPO_RST;
         gpo_lvl_q <= GPO_RST;
         ratio_q <= DIV_RATIO_RST;
         flush_pend_q <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         sclk_q <= sclk_d;
         active_q <= active_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         mode_q <= mode_d;
         read_pend_q <= read_pend_d;
         key_sh_q <= key_sh_d;
         key_oe_n_q <= key_oe_n_d;
         drive_q <= drive_d;
         pin_q <= pin_d;
         gpo_en_q <= gpo_en_d;
         gpo_lvl_q <= gpo_lvl_d;
         ratio_q <= ratio_d;
         flush_pend_q <= flush_pend_d;
         overrun_q <= overrun_d;
      end
   end

   // buffered path to the ram packer
   logic pk_valid, pk_ready, pk_write, cur_bit;
   fifo_entry_t pk_entry;

   entry_fifo #(.WIDTH($bits(fifo_entry_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_valid),
      .in_data_i(push_entry),
      .in_ready_o(push_ready),
      .out_valid_o(pk_valid),
      .out_data_o(pk_entry),
      .out_ready_i(pk_ready)
   );

   logic [RAM_WIDTH-1:0] ram_q [RAM_DEPTH];
   logic [RAM_WIDTH-1:0] ram_d [RAM_DEPTH];
   logic [RAM_WIDTH-1:0] acc_q, acc_d, new_acc;
   logic [2:0] bit_idx_q, bit_idx_d, grp_q, grp_d, group_len;
   logic [ADDR_W-1:0] addr_q, addr_d;

   assign group_len = drive_q.quarter_duty ? GROUP_QUARTER : GROUP_THIRD;

   always_comb begin
      ram_d = ram_q;
      acc_d = acc_q;
      bit_idx_d = bit_idx_q;
      grp_d = grp_q;
      addr_d = addr_q;
      pk_ready = 1'b0;
      pk_write = 1'b0;
      cur_bit = pk_entry.payload[~bit_idx_q];
      new_acc = acc_q;
      new_acc[grp_q[1:0]] = cur_bit;
      if (pk_valid) begin
         case (pk_entry.kind)
            ENT_DATA: begin
               acc_d = new_acc;
               bit_idx_d = bit_idx_q + 3'h1;
               pk_ready = (bit_idx_q == BYTE_LAST_BIT);
               if (grp_q == group_len - 3'h1) begin
                  pk_write = 1'b1; // R23
                  grp_d = '0;
                  acc_d = '0;
                  if (addr_q <= ADDR_LAST) begin
                     ram_d[addr_q] = drive_q.quarter_duty ? new_acc :
                        {1'b0, new_acc[2:0]}; // R12
                  end
                  addr_d = (addr_q == ADDR_LAST) ? '0 : addr_q + ADDR_ONE; // R13
               end else begin
                  grp_d = grp_q + 3'h1;
               end
            end
            ENT_ADDR: begin
               addr_d = pk_entry.payload[ADDR_W-1:0]; // R13
               grp_d = '0;
               acc_d = '0;
               pk_ready = 1'b1;
            end
            default: begin
               grp_d = '0; // R23
               acc_d = '0;
               pk_ready = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      ram_q <= ram_d;
      if (!rst_n_i) begin
         acc_q <= '0;
         bit_idx_q <= '0;
         grp_q <= '0;
         addr_q <= '0;
      end else begin
         acc_q <= acc_d;
         bit_idx_q <= bit_idx_d;
         grp_q <= grp_d;
         addr_q <= addr_d;
      end
   end

   for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram_out
      assign display_ram_o[i*RAM_WIDTH +: RAM_WIDTH] = ram_q[i];
   end

   // key scan, frame divider and pin roles
   logic [STEP_W-1:0] step_q, step_d;
   logic [2:0] scan_idx_q, scan_idx_d;
   logic scanning_q, scanning_d, step_tick, ext_q, ext_d;
   logic [KEY_SCAN_N-1:0] scan_out_q, scan_out_d;
   logic [FRAME_CNT_W-1:0] frame_cnt_q, frame_cnt_d;
   logic frame_q, frame_d, disp_en_q, disp_en_d;

   always_comb begin
      step_tick = (step_q == STEP_W'(KEY_STEP_CYC - 1));
      step_d = step_tick ? '0 : step_q + 1'b1;
      scanning_d = scanning_q;
      scan_idx_d = scan_idx_q;
      key_d = key_q;
      if (pin_q.key_scan_seg || pin_q.key_sense_seg) begin
         scanning_d = 1'b0; // R17
      end else if (step_tick) begin
         if (!scanning_q) begin
            if (|key_sense_in_i) begin
               scanning_d = 1'b1; // R18
               scan_idx_d = '0;
            end
         end else begin
            for (int i = 0; i < KEY_SCAN_N; i++) begin
               if (scan_idx_q == 3'(i)) begin
                  key_d[i*KEY_SENSE_N +: KEY_SENSE_N] = key_sense_in_i; // R18
               end
            end
            if (scan_idx_q == SCAN_LAST) begin
               scanning_d = 1'b0;
            end else begin
               scan_idx_d = scan_idx_q + 3'h1;
            end
         end
      end
      if (scanning_d) begin
         scan_out_d = SCAN_ONE << scan_idx_d;
      end else begin
         scan_out_d = pin_q.key_scan_seg ? '0 : '1; // R17
      end
      ext_d = ext_clock_in_i;
      frame_d = 1'b0;
      frame_cnt_d = frame_cnt_q;
      if (drive_q.clock_select_field == CLKSEL_EXT) begin
         if (ext_clock_in_i && !ext_q) begin
            if (frame_cnt_q == FRAME_CNT_W'({ratio_q, EXT_DIV_LOW})) begin
               frame_d = 1'b1; // R20
               frame_cnt_d = '0;
            end else begin
               frame_cnt_d = frame_cnt_q + 1'b1;
            end
         end
      end else if (frame_cnt_q == FRAME_CNT_W'(INT_FRAME_DIV - 1)) begin
         frame_d = 1'b1;
         frame_cnt_d = '0;
      end else begin
         frame_cnt_d = frame_cnt_q + 1'b1;
      end
      disp_en_d = pin_q.display_on && reset_in_low_i; // R14
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         step_q <= '0;
         scan_idx_q <= '0;
         scanning_q <= 1'b0;
         key_q <= '0;
         scan_out_q <= '1;
         ext_q <= 1'b0;
         frame_cnt_q <= '0;
         frame_q <= 1'b0;
         disp_en_q <= 1'b0;
      end else begin
         step_q <= step_d;
         scan_idx_q <= scan_idx_d;
         scanning_q <= scanning_d;
         key_q <= key_d;
         scan_out_q <= scan_out_d;
         ext_q <= ext_d;
         frame_cnt_q <= frame_cnt_d;
         frame_q <= frame_d;
         disp_en_q <= disp_en_d;
      end
   end

   assign key_data_out_o = 1'b0;
   assign key_data_oe_n_o = key_oe_n_q;
   assign key_scan_out_o = scan_out_q;
   assign display_enable_o = disp_en_q;
   assign quarter_duty_o = drive_q.quarter_duty; // R19
   assign bias_third_o = drive_q.bias_third;
   assign common4_is_seg41_o = !drive_q.quarter_duty; // R15
   assign gpo_enable_o = gpo_en_q;
   assign gpo_level_o = gpo_lvl_q;
   assign key_scan_is_seg_o = pin_q.key_scan_seg;
   assign key_sense_is_seg_o = pin_q.key_sense_seg;
   assign frame_tick_o = frame_q;
   assign fifo_overrun_o = overrun_q;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_key_cmd;
      fall && bit_cnt_q == BIT_CNT_FULL && mode_q == MODE_CMD && read_pend_q;
   endsequence
   property p_idle_clear;
      !active |=> bit_cnt_q == '0 && mode_q == MODE_CMD;
   endproperty
   a_idle_clear: assert property (p_idle_clear) // R1
      else $error("counter or mode not cleared with select high");
   property p_ignore;
      !active |=> $stable(shift_q);
   endproperty
   a_ignore: assert property (p_ignore) // R2
      else $error("shift register moved while deselected");
   property p_sample;
      rise |=> shift_q[0] == $past(serial_data_in_i) &&
         shift_q[7:1] == $past(shift_q[6:0]);
   endproperty
   a_sample: assert property (p_sample) // R4
      else $error("serial bit not sampled msb first");
   property p_whole_byte;
      push_valid && push_entry.kind != ENT_FLUSH |-> bit_cnt_q == BIT_CNT_FULL;
   endproperty
   a_whole_byte: assert property (p_whole_byte) // R5
      else $error("partial byte acted upon");
   property p_read_enter;
      s_key_cmd |=> mode_q == MODE_READ ##1 (mode_q == MODE_READ || !active_q);
   endproperty
   a_read_enter: assert property (p_read_enter) // R6
      else $error("key read did not enter read mode");
   property p_read_exit;
      mode_q == MODE_READ && !active |=> mode_q == MODE_CMD && key_oe_n_q;
   endproperty
   a_read_exit: assert property (p_read_exit) // R7
      else $error("read mode held after select high");
   property p_data_stays;
      mode_q == MODE_DATA && active |=> mode_q == MODE_DATA;
   endproperty
   a_data_stays: assert property (p_data_stays) // R11
      else $error("left data mode within a select period");
   property p_released;
      mode_q != MODE_READ |-> key_oe_n_q;
   endproperty
   a_released: assert property (p_released) // R24
      else $error("key output driven outside read mode");
   property p_group;
      pk_write |-> grp_q == group_len - 3'h1;
   endproperty
   a_group: assert property (p_group) // R23
      else $error("ram written with wrong group size");
   property p_addr_step;
      pk_write && addr_q < ADDR_LAST |=> addr_q == $past(addr_q) + ADDR_ONE;
   endproperty
   a_addr_step: assert property (p_addr_step) // R13
      else $error("address did not step after a group");
   property p_disp_off;
      !reset_in_low_i |=> !display_enable_o;
   endproperty
   a_disp_off: assert property (p_disp_off) // R14
      else $error("display enabled with reset pin low");
   property p_no_press;
      !scanning_q && key_sense_in_i == '0 |=> !scanning_q;
   endproperty
   a_no_press: assert property (p_no_press) // R18
      else $error("scan started without a key press");
endmodule
`default_nettype wire

/* host_model.sv */
// host side of the three-wire port, with the key line pull-up
// assumes mclk_i at 10 MHz; at least four mclk per serial clock level
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic mclk_i,
   input wire logic oe_n_i,
   input wire logic od_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic sd_o,
   output logic line_o
);
   assign line_o = oe_n_i ? 1'b1 : od_i;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sd_o = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic sel(input logic lvl);
      wait_n(4);
      cs_n_o = lvl;
      if (lvl) sd_o = ~sd_o;
      wait_n(4);
   endtask
   task automatic bits(input logic [7:0] v, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sd_o = v[i];
         wait_n(4);
         sclk_o = 1'b1;
         wait_n(4);
         sclk_o = 1'b0;
         wait_n(4);
      end
   endtask
   task automatic rd(input int n, output logic [31:0] got);
      got = 32'h0;
      for (int i = 0; i < n; i++) begin
         wait_n(4);
         sclk_o = 1'b1;
         wait_n(4);
         got = {got[30:0], line_o};
         sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* test_lcd_serial_command_port.sv */
// testbench of the serial command port
// assumes the host model drives the serial pins
`timescale 1ns/1ns
`default_nettype none
module test_lcd_serial_command_port;
   import lcd_port_pkg::*;
   logic mclk, rst_n, cs_n, sclk, sd, res_n, line, oe_n;
   logic dout, ftk, ovr, ext_clk;
   logic [4:0] press;
   int tick_cnt;
   logic de, qd, bt, c4, kss, kse;
   logic [3:0] ge, gl;
   logic [5:0] scan;
   logic [203:0] ram;
   logic [31:0] got;
   int error_cnt, checks;
   host_model u_host (.mclk_i(mclk), .oe_n_i(oe_n), .od_i(dout),
      .cs_n_o(cs_n), .sclk_o(sclk), .sd_o(sd), .line_o(line));
   lcd_serial_command_port #(.INT_FRAME_DIV(100)) u_dut (
      .mclk_i(mclk), .rst_n_i(rst_n), .chip_select_low_i(cs_n),
      .serial_clock_i(sclk), .serial_data_in_i(sd),
      .reset_in_low_i(res_n), .ext_clock_in_i(ext_clk),
      .key_sense_in_i(press & {5{scan[2]}}),
      .key_data_out_o(dout), .key_data_oe_n_o(oe_n), .key_scan_out_o(scan),
      .display_ram_o(ram), .display_enable_o(de), .quarter_duty_o(qd),
      .bias_third_o(bt), .common4_is_seg41_o(c4), .gpo_enable_o(ge),
      .gpo_level_o(gl), .key_scan_is_seg_o(kss),
      .key_sense_is_seg_o(kse), .frame_tick_o(ftk), .fifo_overrun_o(ovr));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      tick_cnt <= tick_cnt + int'(ftk);
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset();
      chk("oe_n", 1, oe_n);
      chk("scan", 6'h3F, scan);
      chk("duty", 1, qd);
      chk("bias", 0, bt);
      chk("disp", 0, de);
   endtask
   task automatic t_cmds();
      u_host.sel(0);
      u_host.bits(8'h83, 8);
      u_host.bits(8'hE7, 8);
      u_host.sel(1);
      chk("bias", 1, bt);
      chk("disp", 1, de);
      chk("kss", 1, kss);
      chk("kse", 1, kse);
      chk("scan", 6'h00, scan);
      u_host.sel(0);
      u_host.bits(8'h9F, 8);
      u_host.bits(8'hC5, 8);
      u_host.bits(8'hE4, 8);
      u_host.sel(1);
      chk("gpo_en", 4'hF, ge);
      chk("gpo_lv", 4'h5, gl);
      chk("scan", 6'h3F, scan);
   endtask
   task automatic t_partial();
      u_host.sel(0);
      u_host.bits(8'h80, 5);
      u_host.sel(1);
      chk("duty", 1, qd);
      res_n = 1'b0;
      u_host.sel(0);
      u_host.bits(8'h80, 8);
      u_host.sel(1);
      chk("duty", 1, qd);
      chk("disp", 0, de);
      res_n = 1'b1;
   endtask
   task automatic t_write();
      u_host.sel(0);
      u_host.bits(8'h05, 8);
      u_host.bits(8'hA0, 8);
      u_host.bits(8'h5A, 8);
      u_host.bits(8'h00, 8);
      u_host.sel(1);
      u_host.wait_n(20);
      chk("w5", 4'hA, ram[20 +: 4]);
      chk("w6", 4'h5, ram[24 +: 4]);
      chk("w7", 4'h0, ram[28 +: 4]);
      chk("w8", 4'h0, ram[32 +: 4]);
      u_host.sel(0);
      u_host.bits(8'h81, 8);
      u_host.bits(8'h0A, 8);
      u_host.bits(8'hA0, 8);
      u_host.bits(8'hE0, 8);
      u_host.sel(1);
      u_host.wait_n(20);
      chk("c4", 1, c4);
      chk("duty", 0, qd);
      chk("wA", 4'h7, ram[40 +: 4]);
      chk("wB", 4'h0, ram[44 +: 4]);
      u_host.sel(0);
      u_host.bits(8'h0B, 8);
      u_host.bits(8'hA0, 8);
      u_host.bits(8'hFF, 8);
      u_host.sel(1);
      u_host.sel(0);
      u_host.bits(8'hA0, 8);
      u_host.bits(8'h00, 8);
      u_host.bits(8'hFF, 2);
      u_host.sel(1);
      u_host.wait_n(20);
      chk("wB", 4'h7, ram[44 +: 4]);
      chk("wC", 4'h7, ram[48 +: 4]);
      chk("wD", 4'h0, ram[52 +: 4]);
      chk("overrun", 0, ovr);
   endtask
   task automatic t_frame();
      int n;
      n = tick_cnt;
      u_host.wait_n(1000);
      chk("int_tick", 10, tick_cnt - n);
      u_host.sel(0);
      u_host.bits(8'h8E, 8);
      u_host.sel(1);
      chk("c4", 0, c4);
      n = tick_cnt;
      repeat (600) begin
         ext_clk = 1'b1;
         u_host.wait_n(2);
         ext_clk = 1'b0;
         u_host.wait_n(2);
      end
      chk("ext_tick", 2, tick_cnt - n);
   endtask
   task automatic t_read();
      press = 5'h11;
      for (int i = 0; i < 1100 && scan === 6'h3F; i++) begin
         u_host.wait_n(1);
      end
      chk("scan", 6'h01, scan);
      u_host.wait_n(8000);
      u_host.sel(0);
      u_host.bits(8'hB0, 8);
      u_host.rd(20, got);
      chk("key", 32'h00011, got);
      u_host.sel(1);
      chk("oe_n", 1, oe_n);
      press = 5'h00;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      res_n = 1'b1;
      press = 5'h00;
      ext_clk = 1'b0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      t_reset();
      t_cmds();
      t_partial();
      t_write();
      t_read();
      t_frame();
      print_verdict();
   end
endmodule
`default_nettype wire
